// ===== ctec_defines.svh
`ifndef CTEC_DEFINES_SVH
`define CTEC_DEFINES_SVH

// Register byte offsets on the plain register port
`define CTEC_OFS_CTL        4'h0
`define CTEC_OFS_STAT       4'h4

// Control register field positions
`define CTEC_BIT_UNIT_EN    15
`define CTEC_BIT_IDLE_STOP  13
`define CTEC_BIT_TIME_GEN   12
`define CTEC_BIT_EDGE_SRC   11
`define CTEC_BIT_EDGE_ORDER 10
`define CTEC_BIT_DISCHARGE  9
`define CTEC_BIT_CONV_TRIG  8

// Edge status register field positions
`define CTEC_BIT_EDGE1      0
`define CTEC_BIT_EDGE2      1

// Reset values
`define CTEC_CTL_RST        16'h0000
`define CTEC_STAT_RST       16'h0000
`define CTEC_RDATA_RST      16'h0000

`endif

// ===== ctec_pkg.sv
package ctec_pkg;

   // Progress of one charge measurement between the two edges
   typedef enum logic [1:0] {
      CTEC_IDLE   = 2'b00,
      CTEC_CHARGE = 2'b01,
      CTEC_DONE   = 2'b10
   } ctec_phase_t;

   // Implemented control bits, most significant first
   typedef struct packed {
      logic unit_en;
      logic idle_stop;
      logic time_gen;
      logic edge_src;
      logic edge_order;
      logic discharge;
      logic conv_trig;
   } ctec_ctl_t;

   // Register port request from software
   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } ctec_bus_t;

   // Hardware edge sources
   typedef struct packed {
      logic edge1;
      logic edge2;
   } ctec_edges_t;

   // Drive toward the analog side and the converter
   typedef struct packed {
      logic src_on;
      logic src_gnd;
      logic adc_soc;
      logic delay_en;
   } ctec_ana_t;

   // Whole state of the block
   typedef struct packed {
      ctec_ctl_t   ctl;
      logic        edge1_stat;
      logic        edge2_stat;
      ctec_phase_t phase;
      logic [15:0] rdata;
      ctec_ana_t   ana;
   } ctec_state_t;

endpackage

// ===== ctec_top.sv
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`include "ctec_defines.svh"

module ctec_top (
   // Clock and reset
   input  wire logic               mclk,
   input  wire logic               rst_n,
   // Register port
   input  wire ctec_pkg::ctec_bus_t bus,
   output logic [15:0]              rdata,
   // Device power state
   input  wire logic               idle_mode,
   // Hardware edge sources, one-cycle pulses
   input  wire ctec_pkg::ctec_edges_t hw_edges,
   // Analog and converter control
   output ctec_pkg::ctec_ana_t     ana,
   // Measurement progress
   output logic                    edge1_stat,
   output logic                    edge2_stat
);

   ctec_pkg::ctec_state_t state_r;
   ctec_pkg::ctec_state_t state_nxt;

   logic active;
   logic hw_e1;
   logic hw_e2;
   logic sw_stat_wr;
   logic e1_nxt;
   logic e2_nxt;

   // Edge 2 may only count once edge 1 is present when ordering is on
   function automatic logic edge2_allowed(input logic order, input logic e1);
      edge2_allowed = !order || e1;
   endfunction

   // Pack the implemented control bits into the register view
   function automatic logic [15:0] ctl_word(input ctec_pkg::ctec_ctl_t c);
      logic [15:0] w;
      w = `CTEC_CTL_RST;
      w[`CTEC_BIT_UNIT_EN]    = c.unit_en;
      w[`CTEC_BIT_IDLE_STOP]  = c.idle_stop;
      w[`CTEC_BIT_TIME_GEN]   = c.time_gen;
      w[`CTEC_BIT_EDGE_SRC]   = c.edge_src;
      w[`CTEC_BIT_EDGE_ORDER] = c.edge_order;
      w[`CTEC_BIT_DISCHARGE]  = c.discharge;
      w[`CTEC_BIT_CONV_TRIG]  = c.conv_trig;
      ctl_word = w;
   endfunction

   // Next state of the whole block
   always_comb begin
      state_nxt = state_r;
      // Enabled and not parked by Idle mode
      active = state_r.ctl.unit_en && !(state_r.ctl.idle_stop && idle_mode);
      // Hardware edges only count in hardware trigger mode
      hw_e1 = active && state_r.ctl.edge_src && hw_edges.edge1;
      hw_e2 = active && state_r.ctl.edge_src && hw_edges.edge2
              && edge2_allowed(state_r.ctl.edge_order, state_r.edge1_stat || hw_e1);
      sw_stat_wr = bus.wr && (bus.addr == `CTEC_OFS_STAT);

      // Control register write; low byte and bit 14 are not stored
      if (bus.wr && (bus.addr == `CTEC_OFS_CTL)) begin
         state_nxt.ctl.unit_en    = bus.wdata[`CTEC_BIT_UNIT_EN];
         state_nxt.ctl.idle_stop  = bus.wdata[`CTEC_BIT_IDLE_STOP];
         state_nxt.ctl.time_gen   = bus.wdata[`CTEC_BIT_TIME_GEN];
         state_nxt.ctl.edge_src   = bus.wdata[`CTEC_BIT_EDGE_SRC];
         state_nxt.ctl.edge_order = bus.wdata[`CTEC_BIT_EDGE_ORDER];
         state_nxt.ctl.discharge  = bus.wdata[`CTEC_BIT_DISCHARGE];
         state_nxt.ctl.conv_trig  = bus.wdata[`CTEC_BIT_CONV_TRIG];
      end

      // Edge status: software may always clear, but sets only in software mode.
      // A hardware edge in the same cycle as a clearing write wins.
      e1_nxt = state_r.edge1_stat;
      e2_nxt = state_r.edge2_stat;
      if (sw_stat_wr) begin
         e1_nxt = bus.wdata[`CTEC_BIT_EDGE1]
                  && (state_r.edge1_stat || (active && !state_r.ctl.edge_src));
         e2_nxt = bus.wdata[`CTEC_BIT_EDGE2]
                  && (state_r.edge2_stat || (active && !state_r.ctl.edge_src
                  && edge2_allowed(state_r.ctl.edge_order, e1_nxt)));
      end
      state_nxt.edge1_stat = e1_nxt || hw_e1;
      state_nxt.edge2_stat = e2_nxt || hw_e2;

      // Measurement phase follows the edge status bits while running
      state_nxt.ana.adc_soc = 1'b0;
      if (!state_r.ctl.unit_en) begin
         state_nxt.phase = ctec_pkg::CTEC_IDLE;
      end else if (active) begin
         case (state_r.phase)
            ctec_pkg::CTEC_IDLE: begin
               if (state_nxt.edge1_stat && !state_nxt.edge2_stat) begin
                  state_nxt.phase = ctec_pkg::CTEC_CHARGE;
               end
            end
            ctec_pkg::CTEC_CHARGE: begin
               if (state_nxt.edge2_stat) begin
                  state_nxt.phase = ctec_pkg::CTEC_DONE;
                  // One start pulse per completed window
                  state_nxt.ana.adc_soc = state_r.ctl.conv_trig;
               end else if (!state_nxt.edge1_stat) begin
                  state_nxt.phase = ctec_pkg::CTEC_IDLE;
               end
            end
            ctec_pkg::CTEC_DONE: begin
               if (!state_nxt.edge1_stat && !state_nxt.edge2_stat) begin
                  state_nxt.phase = ctec_pkg::CTEC_IDLE;
               end
            end
            default: begin
               state_nxt.phase = ctec_pkg::CTEC_IDLE;
            end
         endcase
      end

      // Analog drive; grounding follows the bit alone, never the phase
      state_nxt.ana.src_gnd  = state_r.ctl.discharge;
      state_nxt.ana.src_on   = active && (state_nxt.phase == ctec_pkg::CTEC_CHARGE);
      state_nxt.ana.delay_en = active && state_r.ctl.time_gen;

      // Read data stands for one cycle only; unmapped reads return zero
      state_nxt.rdata = `CTEC_RDATA_RST;
      if (bus.rd) begin
         if (bus.addr == `CTEC_OFS_CTL) begin
            state_nxt.rdata = ctl_word(state_r.ctl);
         end else if (bus.addr == `CTEC_OFS_STAT) begin
            state_nxt.rdata[`CTEC_BIT_EDGE1] = state_r.edge1_stat;
            state_nxt.rdata[`CTEC_BIT_EDGE2] = state_r.edge2_stat;
         end
      end
   end

   // State register, synchronous reset to all zero
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Outputs come straight from the state register
   assign rdata      = state_r.rdata;
   assign ana        = state_r.ana;
   assign edge1_stat = state_r.edge1_stat;
   assign edge2_stat = state_r.edge2_stat;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_ctl_read;
      bus.rd && (bus.addr == `CTEC_OFS_CTL);
   endsequence

   sequence s_sw_set_e1;
      bus.wr && (bus.addr == `CTEC_OFS_STAT) && bus.wdata[`CTEC_BIT_EDGE1]
      && state_r.ctl.unit_en && !state_r.ctl.edge_src
      && !(state_r.ctl.idle_stop && idle_mode);
   endsequence

   a_hw_edge_ignored: assert property (
      (!state_r.ctl.edge_src && !sw_stat_wr && !state_r.edge1_stat)
      |=> !edge1_stat)
      else $error("edge 1 set without a software write in software mode");

   a_sw_edge_set: assert property (s_sw_set_e1 |=> edge1_stat)
      else $error("software edge 1 set was lost");

   // Ordering is judged by the bit that stood when edge 2 was taken
   a_edge_order: assert property (
      ($rose(edge2_stat) && $past(state_r.ctl.edge_order))
      |-> edge1_stat)
      else $error("edge 2 accepted before edge 1");

   a_ground_follow: assert property (
      ##1 (ana.src_gnd == $past(state_r.ctl.discharge)))
      else $error("ground output does not follow discharge bit");

   a_adc_gate: assert property (
      ana.adc_soc |-> $past(state_r.ctl.conv_trig) && (state_r.phase == ctec_pkg::CTEC_DONE))
      else $error("converter start without trigger bit");

   a_low_zero: assert property (s_ctl_read |=> (rdata[7:0] == 8'h00) && !rdata[14])
      else $error("unimplemented control bits read nonzero");

   a_delay_gen: assert property (
      ana.delay_en |-> $past(state_r.ctl.time_gen) && $past(state_r.ctl.unit_en))
      else $error("delay generation without enable");

   a_no_auto_dis: assert property (
      (!state_r.ctl.discharge)[*2] |-> !ana.src_gnd)
      else $error("capacitor grounded without discharge bit");

   a_disabled_idle: assert property (
      !state_r.ctl.unit_en |=> (state_r.phase == ctec_pkg::CTEC_IDLE) && !ana.src_on)
      else $error("disabled unit left measuring");

   a_idle_halt: assert property (
      (state_r.ctl.idle_stop && idle_mode) |=> !ana.src_on && !ana.delay_en && !ana.adc_soc)
      else $error("unit kept running in Idle mode");

   a_time_generation_bit_pos: assert property (
      s_ctl_read |=> rdata[`CTEC_BIT_TIME_GEN] == $past(state_r.ctl.time_gen))
      else $error("time generation bit read back at wrong position");

   a_reset_zero: assert property (
      $rose(rst_n) |-> (state_r.ctl == '0) && !ana.adc_soc)
      else $error("control bits not zero after reset");

   // Hardware edge 1 taken while the unit runs in hardware mode
   sequence s_hw_take_e1;
      hw_edges.edge1 && state_r.ctl.unit_en && state_r.ctl.edge_src
      && !(state_r.ctl.idle_stop && idle_mode);
   endsequence

   // Software edge 2 set with ordering off needs no edge 1
   sequence s_sw_set_e2_free;
      bus.wr && (bus.addr == `CTEC_OFS_STAT) && bus.wdata[`CTEC_BIT_EDGE2]
      && state_r.ctl.unit_en && !state_r.ctl.edge_src && !state_r.ctl.edge_order
      && !(state_r.ctl.idle_stop && idle_mode);
   endsequence

   // Read of the edge status word
   sequence s_stat_read;
      bus.rd && (bus.addr == `CTEC_OFS_STAT);
   endsequence

   a_hw_edge_taken: assert property (s_hw_take_e1 |=> edge1_stat)
      else $error("hardware edge 1 lost in hardware mode");

   a_edge_free: assert property (s_sw_set_e2_free |=> edge2_stat)
      else $error("edge 2 refused with ordering off");

   a_stat_read: assert property (
      s_stat_read |=> (rdata[1:0] == {$past(state_r.edge2_stat), $past(state_r.edge1_stat)}))
      else $error("edge status read back wrong");

   // A held start would make the converter run twice
   a_soc_single: assert property (ana.adc_soc |=> !ana.adc_soc)
      else $error("converter start longer than one cycle");

   a_read_quiet: assert property (!bus.rd |=> (rdata == `CTEC_RDATA_RST))
      else $error("read data present without a read");

endmodule

// ===== ctec_far_model.sv
`timescale 1ns/10ps
module ctec_far_model (
   // Clock
   input  wire logic                mclk,
   // Drive from the block
   input  wire ctec_pkg::ctec_ana_t ana,
   // Timer and edge pin sources
   output ctec_pkg::ctec_edges_t    hw_edges,
   // Conversions started so far
   output logic [7:0]               soc_cnt
);
   // Idle sources at time zero
   initial begin
      hw_edges = '0;
      soc_cnt = 8'h00;
   end

   // Converter counts start pulses; a stuck level would count twice
   always @(posedge mclk) begin
      if (ana.adc_soc) begin
         soc_cnt <= soc_cnt + 8'h01;
      end
   end

   // One-cycle edge event from a source
   task automatic pulse(input logic e1, input logic e2);
      @(posedge mclk);
      hw_edges <= '{edge1: e1, edge2: e2};
      @(posedge mclk);
      hw_edges <= '0;
   endtask
endmodule

// ===== tb.sv
`timescale 1ns/10ps
`include "ctec_defines.svh"
module tb;
   logic                  mclk;
   logic                  rst_n;
   logic                  idle_mode;
   ctec_pkg::ctec_bus_t   bus;
   logic [15:0]           rdata;
   ctec_pkg::ctec_edges_t hw_edges;
   ctec_pkg::ctec_ana_t   ana;
   logic                  edge1_stat;
   logic                  edge2_stat;
   logic [7:0]            soc_cnt;
   int                    fails;
   int                    n_checks;

   // 20 MHz clock
   initial mclk = 1'b0;
   always #25 mclk = ~mclk;

   // Block and its far side
   ctec_top ctec_top_inst (.mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
      .idle_mode(idle_mode), .hw_edges(hw_edges), .ana(ana),
      .edge1_stat(edge1_stat), .edge2_stat(edge2_stat));
   ctec_far_model ctec_far_model_inst (.mclk(mclk), .ana(ana), .hw_edges(hw_edges),
      .soc_cnt(soc_cnt));

   // Compare and report
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
      end
   endtask

   // Status bits as one word
   function automatic logic [15:0] stat();
      return {14'h0, edge2_stat, edge1_stat};
   endfunction

   // One-cycle write
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus.wr <= 1'b0;
      #1;
   endtask

   // One-cycle read; data stand only in the next cycle
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge mclk);
      bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      bus.rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask

   task automatic t_reset();
      rd(`CTEC_OFS_CTL, 16'h0000);
      rd(`CTEC_OFS_STAT, 16'h0000);
      chk({12'h000, ana}, 16'h0000);
   endtask

   task automatic t_layout();
      // All control bits written: read-back, ground and delay drive, then an unmapped read
      wr(`CTEC_OFS_CTL, 16'hFFFF);
      rd(`CTEC_OFS_CTL, 16'hBF00);
      chk({15'h0000, ana.src_gnd}, 16'h0001);
      chk({15'h0000, ana.delay_en}, 16'h0001);
      rd(4'h8, 16'h0000);
      wr(`CTEC_OFS_CTL, 16'h8000);
      rd(`CTEC_OFS_CTL, 16'h8000);
      chk({15'h0000, ana.delay_en}, 16'h0000);
      chk({15'h0000, ana.src_gnd}, 16'h0000);
   endtask

   task automatic t_hw();
      wr(`CTEC_OFS_CTL, 16'h8D00);
      ctec_far_model_inst.pulse(1'b0, 1'b1);
      #1 chk(stat(), 16'h0000);
      ctec_far_model_inst.pulse(1'b1, 1'b0);
      #1 chk(stat(), 16'h0001);
      chk({15'h0000, ana.src_on}, 16'h0001);
      ctec_far_model_inst.pulse(1'b0, 1'b1);
      #1 chk(stat(), 16'h0003);
      chk({15'h0000, ana.src_on}, 16'h0000);
      @(posedge mclk);
      #1 chk({8'h00, soc_cnt}, 16'h0001);
      rd(`CTEC_OFS_STAT, 16'h0003);
      wr(`CTEC_OFS_STAT, 16'h0000);
      wr(`CTEC_OFS_CTL, 16'h8C00);
      ctec_far_model_inst.pulse(1'b1, 1'b0);
      ctec_far_model_inst.pulse(1'b0, 1'b1);
      repeat (2) @(posedge mclk);
      #1 chk({8'h00, soc_cnt}, 16'h0001);
   endtask

   task automatic t_sw();
      wr(`CTEC_OFS_STAT, 16'h0000);
      wr(`CTEC_OFS_CTL, 16'h8400);
      ctec_far_model_inst.pulse(1'b1, 1'b1);
      #1 chk(stat(), 16'h0000);
      wr(`CTEC_OFS_STAT, 16'h0002);
      chk(stat(), 16'h0000);
      wr(`CTEC_OFS_STAT, 16'h0001);
      chk(stat(), 16'h0001);
      // Ordering off: edge 2 alone is accepted
      wr(`CTEC_OFS_STAT, 16'h0000);
      wr(`CTEC_OFS_CTL, 16'h8000);
      wr(`CTEC_OFS_STAT, 16'h0002);
      chk(stat(), 16'h0002);
   endtask

   task automatic t_idle();
      wr(`CTEC_OFS_STAT, 16'h0000);
      wr(`CTEC_OFS_CTL, 16'h0800);
      ctec_far_model_inst.pulse(1'b1, 1'b0);
      #1 chk(stat(), 16'h0000);
      wr(`CTEC_OFS_CTL, 16'hA800);
      @(posedge mclk);
      idle_mode <= 1'b1;
      ctec_far_model_inst.pulse(1'b1, 1'b0);
      #1 chk(stat(), 16'h0000);
      @(posedge mclk);
      idle_mode <= 1'b0;
      ctec_far_model_inst.pulse(1'b1, 1'b0);
      #1 chk(stat(), 16'h0001);
   endtask

   // Verdict and end of run
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      bus = '0;
      idle_mode = 1'b0;
      rst_n = 1'b0;
      fails = 0;
      n_checks = 0;
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      t_reset();
      t_layout();
      t_hw();
      t_sw();
      t_idle();
      end_of_test();
   end

   // Run needs some 80 cycles; cut a hang well past that
   initial begin
      #100000;
      fails++;
      end_of_test();
   end
endmodule
